// ==== sim/tb_wavetable_voice_player.sv ====
/*
 * Self-checking bench for the wavetable voice player.
 * Assumes the rom model, checker and design are compiled before it.
 */
`default_nettype none

module tb_wavetable_voice_player;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 64; // shortened output period
	logic clk; // system clock
	logic rst; // synchronous reset
	wvp_pkg::wvp_reg_req_type req; // processor access
	logic [7:0] rdata; // read data
	logic rom_req; // fetch request
	logic rom_ack; // fetch answer
	logic [3:0] rom_wait; // rom wait cycles
	logic [15:0] rom_addr; // fetch word
	logic [15:0] rom_data; // fetched word
	logic dac_on; // converter power
	logic [15:0] dac_data; // converter word
	int err_count; // mismatches
	int tests_run; // comparisons

	// player under test
	wvp_top #(.TICK_CYCLES(TICK)) dut_u (.CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
		.ROM_REQ(rom_req), .ROM_ADDR(rom_addr), .ROM_ACK(rom_ack), .ROM_DATA(rom_data),
		.DAC_ON(dac_on), .DAC_DATA(dac_data));

	// sample rom partner
	wvp_rom_model rom_u (.clk(clk), .rst(rst), .req(rom_req), .addr(rom_addr), .wait_n(rom_wait),
		.ack(rom_ack), .data(rom_data));

	// compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one-cycle byte write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) req = '{1'b1, 1'b0, a, d};
		@(negedge clk) req.wr = 1'b0;
	endtask

	// one-cycle byte read, data a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) req.rd = 1'b0;
		d = rdata;
	endtask

	// outputs idle after reset
	task automatic t_reset();
		logic [7:0] d;
		chk({dac_on, rom_req, rdata, 6'h0}, 16'h0, "idle outputs");
		chk(dac_data, 16'h0, "converter after reset");
		rd(8'h1f, d);
		chk({8'h0, d}, 16'h0, "control after reset");
		$display("test reset done");
	endtask

	// every register except the trigger keeps its implemented bits, gaps read zero
	task automatic t_regs();
		logic [7:0] ad [13];
		logic [7:0] mk [13];
		logic [7:0] d;
		logic [7:0] v;
		ad = '{8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2a, 8'h28, 8'h29};
		mk = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h07, 8'hff, 8'h83, 8'hff, 8'h03, 8'hff, 8'h00, 8'h00};
		for (int k = 0; k < 2; k++)
		begin
			v = k ? 8'h5a : 8'hff;
			foreach (ad[i])
				wr(ad[i], v);
			foreach (ad[i])
			begin
				rd(ad[i], d);
				chk({ad[i], d}, {ad[i], v & mk[i]}, "register readback");
			end
		end
		wr(8'h1f, 8'h00);
		$display("test registers done");
	endtask

	// processor word drives the converter only while powered
	task automatic t_dac();
		wr(8'h1d, 8'ha5);
		wr(8'h1e, 8'h3c);
		wr(8'h1f, 8'h02);
		repeat (3) @(negedge clk);
		chk({15'h0, dac_on}, 16'h1, "power on");
		chk(dac_data, 16'ha53c, "processor word");
		wr(8'h1e, 8'hc3);
		repeat (3) @(negedge clk);
		chk(dac_data, 16'ha5c3, "low byte update");
		wr(8'h1f, 8'h00);
		repeat (3) @(negedge clk);
		chk({dac_on, dac_data[14:0]}, 16'h0, "power off");
		$display("test converter done");
	endtask

	// key one voice on a one-sample looped section and watch fetches and mix
	task automatic t_play(input logic [2:0] vc, input logic [10:0] st, input logic fmt, input logic neg,
		input logic [3:0] w, input logic [15:0] w0);
		logic [15:0] base;
		logic [15:0] fa;
		logic first;
		logic bad;
		logic late;
		logic nz;
		logic ng;
		logic [7:0] d;
		base = {st, 5'h00};
		rom_wait = w;
		rom_u.mem[base[7:0]] = w0;
		wr(8'h21, 8'h68);
		wr(8'h22, 8'h00);
		wr(8'h23, {5'h00, st[10:8]});
		wr(8'h24, st[7:0]);
		wr(8'h25, {fmt, 7'h03});
		wr(8'h26, 8'hff);
		wr(8'h27, 8'h00);
		wr(8'h2a, 8'h00);
		wr(8'h1f, 8'h03);
		wr(8'h20, {5'h00, vc});
		first = 1'b1;
		bad = 1'b0;
		late = 1'b0;
		nz = 1'b0;
		ng = 1'b0;
		fa = 16'h0;
		for (int i = 0; i < 48 * TICK; i++)
		begin
			@(negedge clk);
			if (rom_req && first)
			begin
				fa = rom_addr;
				first = 1'b0;
			end
			bad |= rom_req && (rom_addr < base || rom_addr > base + 16'h1);
			late |= rom_req && i >= 40 * TICK;
			nz |= dac_data != 16'h0;
			ng |= dac_data[15];
		end
		chk(fa, base, "first fetch word");
		chk({15'h0, bad}, 16'h0, "fetch outside section");
		chk({15'h0, late}, 16'h1, "loop stopped");
		chk({15'h0, nz}, 16'h1, "mix silent");
		chk({15'h0, ng}, {15'h0, neg}, "mix sign");
		rd(8'h20, d);
		chk({8'h0, d}, {12'h000, 1'b1, vc}, "playing flag set");
		$display("test play voice %0d done", vc);
	endtask

	// volume-only write to minimum lets the voice end at its marker
	task automatic t_quiet(input logic [2:0] vc);
		logic busy;
		logic [7:0] d;
		wr(8'h27, 8'h03);
		wr(8'h2a, 8'hff);
		wr(8'h20, {2'b10, 3'h0, vc});
		repeat (40 * TICK) @(negedge clk);
		busy = 1'b0;
		repeat (4 * TICK)
		begin
			@(negedge clk);
			busy |= rom_req || dac_data != 16'h0;
		end
		chk({15'h0, busy}, 16'h0, "voice still sounding");
		rd(8'h20, d);
		chk({8'h0, d}, {8'h0, 2'b10, 3'h0, vc}, "playing flag not cleared");
		// pitch-only update must not restart a stopped voice
		wr(8'h20, {2'b01, 3'h0, vc});
		busy = 1'b0;
		repeat (4 * TICK)
		begin
			@(negedge clk);
			busy |= rom_req;
		end
		chk({15'h0, busy}, 16'h0, "pitch update restarted voice");
		$display("test quiet done");
	endtask

	// print counts and verdict, then stop
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// main sequence
	initial
	begin
		rst = 1'b1;
		req = '0;
		rom_wait = 4'h0;
		err_count = 0;
		tests_run = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_regs();
		t_dac();
		t_play(3'd2, 11'h005, 1'b0, 1'b0, 4'h0, 16'h1080);
		t_quiet(3'd2);
		t_play(3'd5, 11'h006, 1'b1, 1'b1, 4'h3, 16'hf008);
		results();
	end

	// watchdog well beyond the expected run
	initial
	begin
		repeat (40000) @(posedge clk);
		err_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end
endmodule // tb_wavetable_voice_player

`default_nettype wire

// ==== sim/wvp_rom_model.sv ====
/*
 * Shared sample rom answering the player's two-word fetches after a wait.
 * Assumes the bench loads sample words into the array while playback is idle.
 */
`default_nettype none

module wvp_rom_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fetch request from the player
	input wire logic req,
	input wire logic [15:0] addr,
	input wire logic [3:0] wait_n,
	// answer to the player
	output logic ack,
	output logic [15:0] data
);
	logic [15:0] mem [256]; // sample words
	logic [3:0] cnt_q; // wait cycles spent on this word

	// empty rom reads as zero samples
	initial
	begin
		foreach (mem[i])
			mem[i] = 16'h0000;
	end

	// answer after wait_n cycles; data scrambles outside the ack cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack <= 1'b0;
			cnt_q <= 4'h0;
			data <= 16'h0000;
		end
		else if (req && !ack && cnt_q >= wait_n)
		begin
			ack <= 1'b1;
			cnt_q <= 4'h0;
			data <= mem[addr[7:0]];
		end
		else
		begin
			ack <= 1'b0;
			cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
			data <= ~data;
		end
	end
endmodule // wvp_rom_model

`default_nettype wire

// ==== sim/wvp_top_chk.sv ====
/*
 * Port checker for the wavetable voice player.
 * Assumes it is bound to every wvp_top instance and sees its ports only.
 */
`default_nettype none

module wvp_chk (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register port
	input wire wvp_pkg::wvp_reg_req_type REG_REQ,
	input wire logic [7:0] REG_RDATA,
	// rom port and converter
	input wire logic ROM_REQ,
	input wire logic [15:0] ROM_ADDR,
	input wire logic ROM_ACK,
	input wire logic DAC_ON,
	input wire logic [15:0] DAC_DATA
);
	logic [1:0] ctl_q; // shadow of power and source bits
	logic [15:0] word_q; // shadow of the processor word
	logic odd_q; // first word of a pair already taken

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// shadow control bits, cleared by reset
	always_ff @(posedge CLK)
	begin
		if (RST)
			ctl_q <= 2'h0;
		else if (REG_REQ.wr && REG_REQ.addr == 8'h1f)
			ctl_q <= REG_REQ.wdata[1:0];
	end

	// shadow converter bytes, never reset
	always_ff @(posedge CLK)
	begin
		if (REG_REQ.wr && REG_REQ.addr == 8'h1d)
			word_q[15:8] <= REG_REQ.wdata;
		if (REG_REQ.wr && REG_REQ.addr == 8'h1e)
			word_q[7:0] <= REG_REQ.wdata;
	end

	// track which word of the pair is answered
	always_ff @(posedge CLK)
	begin
		if (RST)
			odd_q <= 1'b0;
		else if (ROM_REQ && ROM_ACK)
			odd_q <= !odd_q;
	end

	sequence ctl_wr_s;
		REG_REQ.wr && REG_REQ.addr == 8'h1f;
	endsequence

	sequence ack_s;
		ROM_REQ && ROM_ACK;
	endsequence

	power_follow_a: assert property (ctl_wr_s |-> ##2 DAC_ON == $past(REG_REQ.wdata[1], 2))
		else $error("converter power did not follow the control write");
	off_zero_a: assert property (!DAC_ON |-> DAC_DATA == 16'h0)
		else $error("converter word not zero while off");
	mcu_word_a: assert property ($past(ctl_q) == 2'b10 |-> DAC_DATA == $past(word_q))
		else $error("converter word differs from processor bytes");
	ctl_read_a: assert property (REG_REQ.rd && REG_REQ.addr == 8'h1f |=> REG_RDATA == {6'h00, $past(ctl_q)})
		else $error("control readback wrong");
	unmapped_zero_a: assert property (REG_REQ.rd && (REG_REQ.addr < 8'h1d || REG_REQ.addr > 8'h2a
		|| REG_REQ.addr == 8'h28 || REG_REQ.addr == 8'h29) |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!REG_REQ.rd |=> $stable(REG_RDATA))
		else $error("read data changed without a read");
	rom_hold_a: assert property (ROM_REQ && !ROM_ACK |=> ROM_REQ && $stable(ROM_ADDR))
		else $error("rom request not held");
	rom_step_a: assert property (ack_s ##0 !odd_q |=> ROM_REQ && ROM_ADDR == $past(ROM_ADDR) + 16'h1)
		else $error("second rom word not at next address");
	rom_drop_a: assert property (ack_s ##0 odd_q |=> !ROM_REQ)
		else $error("rom request not dropped after pair");
endmodule // wvp_chk

bind wvp_top wvp_chk chk_u (.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .ROM_REQ(ROM_REQ),
	.ROM_ADDR(ROM_ADDR), .ROM_ACK(ROM_ACK), .DAC_ON(DAC_ON), .DAC_DATA(DAC_DATA));

`default_nettype wire

// ==== src/wvp_defs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * wavetable voice player.
 * Assumes a single system clock and byte-wide processor register accesses.
 */
`ifndef WVP_DEFS_SVH
`define WVP_DEFS_SVH

// register offsets in processor data memory
`define WVP_ADDR_DAC_HI 8'h1d
`define WVP_ADDR_DAC_LO 8'h1e
`define WVP_ADDR_DAC_CTL 8'h1f
`define WVP_ADDR_TRIGGER 8'h20
`define WVP_ADDR_PITCH_HI 8'h21
`define WVP_ADDR_PITCH_LO 8'h22
`define WVP_ADDR_START_HI 8'h23
`define WVP_ADDR_START_LO 8'h24
`define WVP_ADDR_LOOP_HI 8'h25
`define WVP_ADDR_LOOP_LO 8'h26
`define WVP_ADDR_VOL_HI 8'h27
`define WVP_ADDR_VOL_LO 8'h2a

// field positions
`define WVP_CTL_POWER_BIT 1
`define WVP_CTL_SOURCE_BIT 0
`define WVP_TRIG_LEVEL_BIT 7
`define WVP_TRIG_PITCH_BIT 6
`define WVP_TRIG_PLAYING_BIT 3
`define WVP_FMT_WIDTH_BIT 7

// reset values and codes
`define WVP_CTL_RESET 2'h0
`define WVP_END_MARK8 8'h80
`define WVP_END_MARK12 12'h800
`define WVP_ATTEN_SILENT 10'h3ff
`define WVP_GAIN_FULL 11'h400
`define WVP_FRAC_BITS 17

// timing: output sample rate against the system clock
`define WVP_CLK_HZ 200000000
`define WVP_OUT_RATE_HZ 25000
`define WVP_FIFO_DEPTH 16

`endif

// ==== src/wvp_pkg.sv ====
/*
 * Types shared by the wavetable voice player.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none

package wvp_pkg;

	// one voice parameter set
	typedef struct packed {
		logic [3:0] octave_shift;
		logic [11:0] pitch_increment;
		logic [10:0] entry_block_index;
		logic sample_width_flag;
		logic [9:0] loop_offset;
		logic [9:0] attenuation_level;
	} wvp_voice_type;

	// one processor register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wvp_reg_req_type;

	// mixing sequencer states
	typedef enum logic [2:0] {
		ST_VOICE = 3'b000,
		ST_FETCH0 = 3'b001,
		ST_FETCH1 = 3'b010,
		ST_CALC = 3'b011,
		ST_NEXT = 3'b100,
		ST_PUSH = 3'b101
	} wvp_state_type;

endpackage

`default_nettype wire

// ==== src/wvp_top.sv ====
/*
 * Eight-voice wavetable player: processor registers, ROM sample fetch,
 * per-voice stepping and looping, attenuation, mixing, a sample FIFO and the
 * 16-bit converter output register.
 * Assumes the processor core gives single-cycle byte accesses, and the shared
 * ROM answers a held request with a one-cycle acknowledge carrying the word.
 */
// Notes on behaviour
// (R1) power bit turns converter on, off by default
// (R2) source bit picks mixer or processor word
// (R3) processor word is two unreset bytes
// (R4) voice index write selects and keys on
// (R5) software sets parameters before the trigger write
// (R6) change-select bits limit which parameters update
// (R7) 800H at octave 6 steps one sample
// (R8) step is pitch over two^(17-octave), 25kHz
// (R9) start block forms pointer bits 15..5
// (R10) software aligns sections to 32 words
// (R11) width flag picks 8-bit or 12-bit samples
// (R12) play once, then loop until silent
// (R13) loop address is end plus offset, no carry
// (R14) software loads loop offset as negative length
// (R15) attenuation 000H loudest, 3FFH quietest
// (R16) sample 80H marks section end
// (R17) 8-bit samples are signed two's complement
// (R18) parameter bytes sit at 21H through 2AH
// (R19) eight parameter sets summed into converter word
// (R20) software ends sections with the marker only
`default_nettype none
`include "wvp_defs.svh"

// sample buffer between the mixer and the converter
module wvp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage flops
	logic [AW-1:0] wr_ptr_q; // next slot to fill
	logic [AW-1:0] rd_ptr_q; // oldest slot
	logic [AW:0] count_q; // words held
	logic push; // accepted write
	logic pop; // accepted read

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage write
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // wvp_fifo

module wvp_top #(
	// cycles per output sample, shortened in simulation
	parameter int TICK_CYCLES = `WVP_CLK_HZ / `WVP_OUT_RATE_HZ
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// processor register port
	input wire wvp_pkg::wvp_reg_req_type REG_REQ,
	output logic [7:0] REG_RDATA,
	// shared sample ROM port
	output logic ROM_REQ,
	output logic [15:0] ROM_ADDR,
	input wire logic ROM_ACK,
	input wire logic [15:0] ROM_DATA,
	// converter
	output logic DAC_ON,
	output logic [15:0] DAC_DATA
);
	// register state
	logic [15:0] converter_word_q; // processor-written word
	logic converter_power_q; // converter on
	logic converter_source_q; // 1 = mixer path
	logic [7:0] trigger_q; // last voice_index byte written
	wvp_pkg::wvp_voice_type stage_q; // parameters staged for the next trigger
	logic [7:0] rdata_q; // read data register

	// per-voice state
	wvp_pkg::wvp_voice_type voice_q [8]; // live parameters
	logic [32:0] pos_q [8]; // sample index with fraction
	logic [7:0] active_q; // voice playing

	// sequencer
	wvp_pkg::wvp_state_type state_q;
	logic [2:0] vsel_q; // voice being mixed
	logic [15:0] cur_q; // first fetched word
	logic [15:0] nxt_q; // following word
	logic [17:0] acc_q; // signed mix sum
	logic rom_req_q;
	logic [15:0] rom_addr_q;

	// output pacing
	logic [15:0] tick_cnt_q;
	logic tick_q; // one cycle per output sample
	logic [15:0] mix_q; // mixed word shown to converter
	logic dac_on_q;
	logic [15:0] dac_data_q;

	// decoded access
	logic wr_en;
	logic [7:0] wd;
	logic keyon;
	logic [2:0] key_v;
	logic [15:0] mix_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;

	assign wr_en = REG_REQ.wr;
	assign wd = REG_REQ.wdata;
	// (R4) trigger on index write
	assign keyon = wr_en && (REG_REQ.addr == `WVP_ADDR_TRIGGER);
	assign key_v = wd[2:0];

	// current voice datapath
	wvp_pkg::wvp_voice_type vp;
	logic [15:0] n_idx; // integer sample index
	logic [17:0] nib; // nibble index, three per wide sample
	logic [15:0] word_off;
	logic [15:0] word0; // ROM word holding the sample
	logic [31:0] win;
	logic [7:0] s8;
	logic [11:0] s12;
	logic end_hit;
	logic signed [15:0] samp16;
	logic [10:0] gain;
	logic signed [27:0] prod;
	logic signed [17:0] scaled;
	logic [32:0] step;
	logic [15:0] loop_idx;

	always_comb
	begin
		vp = voice_q[vsel_q];
		n_idx = pos_q[vsel_q][32:`WVP_FRAC_BITS];
		nib = {2'b00, n_idx} + {1'b0, n_idx, 1'b0};
		// (R11) address per sample format
		word_off = vp.sample_width_flag ? nib[17:2] : {1'b0, n_idx[15:1]};
		// (R9) start block forms upper pointer bits
		word0 = {vp.entry_block_index, 5'h00} + word_off;
		win = {cur_q, nxt_q};
		s8 = n_idx[0] ? cur_q[7:0] : cur_q[15:8];
		s12 = 12'(win >> (5'd20 - {1'b0, nib[1:0], 2'b00}));
		// (R16) end marker detection
		end_hit = vp.sample_width_flag ? (s12 == `WVP_END_MARK12) : (s8 == `WVP_END_MARK8);
		// (R17) signed raw samples, left aligned
		samp16 = vp.sample_width_flag ? $signed({s12, 4'h0}) : $signed({s8, 8'h00});
		// (R15) 000H full gain, 3FFH least
		gain = `WVP_GAIN_FULL - {1'b0, vp.attenuation_level};
		prod = samp16 * $signed({1'b0, gain});
		scaled = 18'(prod >>> 13);
		// (R7) (R8) step = pitch * 2^octave / 2^17
		step = 33'(vp.pitch_increment) << vp.octave_shift;
		// (R13) end address plus offset, carry dropped
		loop_idx = n_idx + {6'h3f, vp.loop_offset};
	end

	// converter control and word bytes
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			// (R1) converter off after reset
			converter_power_q <= 1'(`WVP_CTL_RESET >> 1);
			converter_source_q <= 1'b0;
		end
		else if (wr_en && REG_REQ.addr == `WVP_ADDR_DAC_CTL)
		begin
			converter_power_q <= wd[`WVP_CTL_POWER_BIT];
			converter_source_q <= wd[`WVP_CTL_SOURCE_BIT];
		end
	end

	// (R3) word bytes hold no reset value
	always_ff @(posedge CLK)
	begin
		if (wr_en && REG_REQ.addr == `WVP_ADDR_DAC_HI)
			converter_word_q[15:8] <= wd;
		if (wr_en && REG_REQ.addr == `WVP_ADDR_DAC_LO)
			converter_word_q[7:0] <= wd;
	end

	// (R18) staged parameter bytes
	always_ff @(posedge CLK)
	begin
		if (keyon)
			trigger_q <= wd;
		if (wr_en)
		begin
			case (REG_REQ.addr)
				`WVP_ADDR_PITCH_HI:
				begin
					stage_q.octave_shift <= wd[7:4];
					stage_q.pitch_increment[11:8] <= wd[3:0];
				end
				`WVP_ADDR_PITCH_LO: stage_q.pitch_increment[7:0] <= wd;
				`WVP_ADDR_START_HI: stage_q.entry_block_index[10:8] <= wd[2:0];
				`WVP_ADDR_START_LO: stage_q.entry_block_index[7:0] <= wd;
				`WVP_ADDR_LOOP_HI:
				begin
					stage_q.sample_width_flag <= wd[`WVP_FMT_WIDTH_BIT];
					stage_q.loop_offset[9:8] <= wd[1:0];
				end
				`WVP_ADDR_LOOP_LO: stage_q.loop_offset[7:0] <= wd;
				`WVP_ADDR_VOL_HI: stage_q.attenuation_level[9:8] <= wd[1:0];
				`WVP_ADDR_VOL_LO: stage_q.attenuation_level[7:0] <= wd;
				default: ; // other addresses hold no parameter
			endcase
		end
	end

	// read back, unmapped addresses read zero
	always_ff @(posedge CLK)
	begin
		if (RST)
			rdata_q <= 8'h00;
		else if (REG_REQ.rd)
		begin
			case (REG_REQ.addr)
				`WVP_ADDR_DAC_HI: rdata_q <= converter_word_q[15:8];
				`WVP_ADDR_DAC_LO: rdata_q <= converter_word_q[7:0];
				`WVP_ADDR_DAC_CTL: rdata_q <= {6'h00, converter_power_q, converter_source_q};
				// playing flag of the selected voice in a spare bit
				`WVP_ADDR_TRIGGER: rdata_q <= {trigger_q[7:6], 2'b00, active_q[trigger_q[2:0]], trigger_q[2:0]};
				`WVP_ADDR_PITCH_HI: rdata_q <= {stage_q.octave_shift, stage_q.pitch_increment[11:8]};
				`WVP_ADDR_PITCH_LO: rdata_q <= stage_q.pitch_increment[7:0];
				`WVP_ADDR_START_HI: rdata_q <= {5'h00, stage_q.entry_block_index[10:8]};
				`WVP_ADDR_START_LO: rdata_q <= stage_q.entry_block_index[7:0];
				`WVP_ADDR_LOOP_HI: rdata_q <= {stage_q.sample_width_flag, 5'h00, stage_q.loop_offset[9:8]};
				`WVP_ADDR_LOOP_LO: rdata_q <= stage_q.loop_offset[7:0];
				`WVP_ADDR_VOL_HI: rdata_q <= {6'h00, stage_q.attenuation_level[9:8]};
				`WVP_ADDR_VOL_LO: rdata_q <= stage_q.attenuation_level[7:0];
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// (R19) live parameter sets, one per voice
	always_ff @(posedge CLK)
	begin
		if (keyon)
		begin
			// (R6) change-select decides what loads
			case ({wd[`WVP_TRIG_LEVEL_BIT], wd[`WVP_TRIG_PITCH_BIT]})
				2'b00: voice_q[key_v] <= stage_q;
				2'b01:
				begin
					voice_q[key_v].octave_shift <= stage_q.octave_shift;
					voice_q[key_v].pitch_increment <= stage_q.pitch_increment;
				end
				2'b10: voice_q[key_v].attenuation_level <= stage_q.attenuation_level;
				default: ; // both bits set: nothing changes
			endcase
		end
	end

	// voice position and playing flags, key-on wins over the engine
	always_ff @(posedge CLK)
	begin
		if (RST)
			active_q <= 8'h00;
		else
		begin
			if (state_q == wvp_pkg::ST_CALC)
			begin
				if (end_hit)
				begin
					// (R12) jump back to loop span
					pos_q[vsel_q] <= {loop_idx, pos_q[vsel_q][`WVP_FRAC_BITS-1:0]};
					// loop ends once the voice is silent
					if (vp.attenuation_level == `WVP_ATTEN_SILENT)
						active_q[vsel_q] <= 1'b0;
				end
				else
					pos_q[vsel_q] <= pos_q[vsel_q] + step;
			end
			// (R4) full update restarts the voice
			if (keyon && wd[`WVP_TRIG_LEVEL_BIT] == 1'b0 && wd[`WVP_TRIG_PITCH_BIT] == 1'b0)
			begin
				pos_q[key_v] <= '0;
				active_q[key_v] <= 1'b1;
			end
		end
	end

	// mixing sequencer: walks all voices once per output sample
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state_q <= wvp_pkg::ST_VOICE;
			vsel_q <= 3'h0;
			acc_q <= 18'h00000;
			rom_req_q <= 1'b0;
			rom_addr_q <= 16'h0000;
			cur_q <= 16'h0000;
			nxt_q <= 16'h0000;
		end
		else
		begin
			case (state_q)
				wvp_pkg::ST_VOICE:
				begin
					// idle voices add nothing
					if (active_q[vsel_q])
					begin
						rom_req_q <= 1'b1;
						rom_addr_q <= word0;
						state_q <= wvp_pkg::ST_FETCH0;
					end
					else
						state_q <= wvp_pkg::ST_NEXT;
				end
				wvp_pkg::ST_FETCH0:
				begin
					// first word, then the one after for straddling samples
					if (ROM_ACK)
					begin
						cur_q <= ROM_DATA;
						rom_addr_q <= rom_addr_q + 16'h0001;
						state_q <= wvp_pkg::ST_FETCH1;
					end
				end
				wvp_pkg::ST_FETCH1:
				begin
					if (ROM_ACK)
					begin
						nxt_q <= ROM_DATA;
						rom_req_q <= 1'b0;
						state_q <= wvp_pkg::ST_CALC;
					end
				end
				wvp_pkg::ST_CALC:
				begin
					// (R16) the marker itself is not mixed
					if (!end_hit)
						acc_q <= acc_q + scaled;
					state_q <= wvp_pkg::ST_NEXT;
				end
				wvp_pkg::ST_NEXT:
				begin
					if (vsel_q == 3'h7)
						state_q <= wvp_pkg::ST_PUSH;
					else
						state_q <= wvp_pkg::ST_VOICE;
					vsel_q <= vsel_q + 3'h1;
				end
				wvp_pkg::ST_PUSH:
				begin
					// stalls here while the buffer is full
					if (fifo_in_ready)
					begin
						acc_q <= 18'h00000;
						state_q <= wvp_pkg::ST_VOICE;
					end
				end
				default: state_q <= wvp_pkg::ST_VOICE;
			endcase
		end
	end

	// (R19) clamp the sum into the 16-bit word
	always_comb
	begin
		if ($signed(acc_q) > 18'sh07fff)
			mix_word = 16'h7fff;
		else if ($signed(acc_q) < -18'sh08000)
			mix_word = 16'h8000;
		else
			mix_word = acc_q[15:0];
	end

	wvp_fifo #(
		.WIDTH(16),
		.DEPTH(`WVP_FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(state_q == wvp_pkg::ST_PUSH),
		.in_ready(fifo_in_ready),
		.in_data(mix_word),
		.out_valid(fifo_out_valid),
		.out_ready(tick_q),
		.out_data(fifo_out_data)
	);

	// (R8) output sample rate divider
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == 16'(TICK_CYCLES - 1))
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// one buffered mix word per output sample
	always_ff @(posedge CLK)
	begin
		if (RST)
			mix_q <= 16'h0000;
		else if (tick_q && fifo_out_valid)
			mix_q <= fifo_out_data;
	end

	// converter output register
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			dac_on_q <= 1'b0;
			dac_data_q <= 16'h0000;
		end
		else
		begin
			// (R1) powered-off converter shows zero
			dac_on_q <= converter_power_q;
			if (!converter_power_q)
				dac_data_q <= 16'h0000;
			// (R2) source select
			else if (converter_source_q)
				dac_data_q <= mix_q;
			else
				dac_data_q <= converter_word_q;
		end
	end

	assign REG_RDATA = rdata_q;
	assign ROM_REQ = rom_req_q;
	assign ROM_ADDR = rom_addr_q;
	assign DAC_ON = dac_on_q;
	assign DAC_DATA = dac_data_q;
endmodule // wvp_top

`default_nettype wire
